// [logic/bri_convert.sv]
// Measurement sequencer: pressure then temperature, trimmed results.
`timescale 1ns/100ps
`default_nettype none
`include "bri_regs.svh"
module bri_convert #(
  parameter int PHASE_CYCLES = `BRI_CONV_CYCLES / 2
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        start_i,
  input  wire logic [23:0] raw_press_i,
  input  wire logic [15:0] raw_temp_i,
  output var  logic        sensor_pwr_o,
  output var  logic        adc_sel_o,
  output var  logic        done_o,
  output var  logic [23:0] press_o,
  output var  logic [15:0] temp_o
);
  bri_pkg::bri_conv_state_type state;
  logic [16:0]                 cnt;
  logic                        phase_end;

  assign phase_end = (cnt == 17'(PHASE_CYCLES - 1));

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= bri_pkg::BRI_CV_SLEEP;
      cnt   <= 17'h00000;
    end else begin
      case (state)
        bri_pkg::BRI_CV_SLEEP: begin
          cnt <= 17'h00000;
          if (start_i) begin
            state <= bri_pkg::BRI_CV_PRESS;
          end
        end
        bri_pkg::BRI_CV_PRESS: begin
          cnt <= phase_end ? 17'h00000 : cnt + 17'h00001;
          if (phase_end) begin
            state <= bri_pkg::BRI_CV_TEMP;
          end
        end
        bri_pkg::BRI_CV_TEMP: begin
          cnt <= phase_end ? 17'h00000 : cnt + 17'h00001;
          if (phase_end) begin
            state <= bri_pkg::BRI_CV_SLEEP;
          end
        end
        default: begin
          state <= bri_pkg::BRI_CV_SLEEP;
          cnt   <= 17'h00000;
        end
      endcase
    end
  end

  // The sensing element is only powered inside the two phases.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensor_pwr_o <= 1'b0;
      adc_sel_o    <= 1'b0;
    end else begin
      sensor_pwr_o <= (state == bri_pkg::BRI_CV_SLEEP) ? start_i
                      : !(state == bri_pkg::BRI_CV_TEMP && phase_end);
      adc_sel_o    <= (state == bri_pkg::BRI_CV_PRESS) ? phase_end
                      : (state == bri_pkg::BRI_CV_TEMP && !phase_end);
    end
  end

  // Results are trimmed and latched at the end of their own phase.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      press_o <= `BRI_PRESS_RESET;
      temp_o  <= `BRI_TEMP_RESET;
      done_o  <= 1'b0;
    end else begin
      done_o <= (state == bri_pkg::BRI_CV_TEMP) && phase_end;
      if (state == bri_pkg::BRI_CV_PRESS && phase_end) begin
        press_o <= raw_press_i + `BRI_PRESS_TRIM;
      end
      if (state == bri_pkg::BRI_CV_TEMP && phase_end) begin
        temp_o <= raw_temp_i + `BRI_TEMP_TRIM;
      end
    end
  end

  property p_start_powers;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (state == bri_pkg::BRI_CV_SLEEP && start_i) |=>
      (sensor_pwr_o && !adc_sel_o && state == bri_pkg::BRI_CV_PRESS);
  endproperty
  a_start_powers: assert property (p_start_powers)
    else $error("Trigger did not start a pressure phase.");

  property p_sleep_unpowered;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (state == bri_pkg::BRI_CV_SLEEP && $past(state) == bri_pkg::BRI_CV_SLEEP)
      |-> !sensor_pwr_o;
  endproperty
  a_sleep_unpowered: assert property (p_sleep_unpowered)
    else $error("Sensor powered while asleep.");

  property p_order;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (state == bri_pkg::BRI_CV_TEMP && $past(state) != bri_pkg::BRI_CV_TEMP)
      |-> $past(state) == bri_pkg::BRI_CV_PRESS && adc_sel_o;
  endproperty
  a_order: assert property (p_order)
    else $error("Temperature phase not preceded by pressure.");
endmodule
`default_nettype wire

// [logic/bri_pkg.sv]
// Types shared by the barometer readout modules.
package bri_pkg;
  typedef enum logic [2:0] {
    BRI_IDLE,
    BRI_ADDR,
    BRI_ADDR_ACK,
    BRI_WR_BYTE,
    BRI_WR_ACK,
    BRI_RD_BYTE,
    BRI_RD_ACK,
    BRI_IGNORE
  } bri_i2c_state_type;
  typedef enum logic [1:0] {
    BRI_CV_SLEEP,
    BRI_CV_PRESS,
    BRI_CV_TEMP
  } bri_conv_state_type;
endpackage

// [logic/bri_readout.sv]
// Barometer readout top: I2C slave, trigger decode and result packet.
`timescale 1ns/100ps
`default_nettype none
`include "bri_regs.svh"
module bri_readout #(
  parameter int CONV_CYCLES = `BRI_CONV_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic [23:0] raw_press_i,
  input  wire logic [15:0] raw_temp_i,
  output var  logic        sensor_pwr_o,
  output var  logic        adc_sel_o,
  output var  logic        busy_o
);
  bri_pkg::bri_i2c_state_type st;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [7:0]  shreg;
  logic [7:0]  byte_now;
  logic [2:0]  bit_cnt;
  logic        ack_on;
  logic        rw;
  logic        got_ptr;
  logic [7:0]  pointer;
  logic [39:0] pkt;
  logic        trig;
  logic        done;
  logic [23:0] press;
  logic [15:0] temp;
  logic        last_bit;

  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond  = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_now   = {shreg[6:0], sda_i};
  assign last_bit   = scl_rise && (bit_cnt == 3'h7);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Bus protocol state, bit counter and receive shifter.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st      <= bri_pkg::BRI_IDLE;
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      ack_on  <= 1'b0;
      rw      <= 1'b0;
    end else if (start_cond) begin
      st      <= bri_pkg::BRI_ADDR;
      bit_cnt <= 3'h0;
      ack_on  <= 1'b0;
    end else if (stop_cond) begin
      st <= bri_pkg::BRI_IDLE;
    end else begin
      if (scl_rise) begin
        shreg   <= byte_now;
        bit_cnt <= bit_cnt + 3'h1;
      end
      case (st)
        bri_pkg::BRI_ADDR: begin
          if (last_bit) begin
            rw <= sda_i;
            st <= (byte_now[7:1] == `BRI_SLAVE_ADDR) ? bri_pkg::BRI_ADDR_ACK
                  : bri_pkg::BRI_IGNORE;
          end
        end
        bri_pkg::BRI_ADDR_ACK, bri_pkg::BRI_WR_ACK: begin
          if (scl_fall) begin
            ack_on <= ~ack_on;
            if (ack_on) begin
              bit_cnt <= 3'h0;
              st <= rw ? bri_pkg::BRI_RD_BYTE : bri_pkg::BRI_WR_BYTE;
            end
          end
        end
        bri_pkg::BRI_WR_BYTE: begin
          if (last_bit) begin
            st <= bri_pkg::BRI_WR_ACK;
          end
        end
        bri_pkg::BRI_RD_BYTE: begin
          if (last_bit) begin
            st <= bri_pkg::BRI_RD_ACK;
          end
        end
        bri_pkg::BRI_RD_ACK: begin
          if (scl_rise) begin
            bit_cnt <= 3'h0;
            st <= sda_i ? bri_pkg::BRI_IGNORE : bri_pkg::BRI_RD_BYTE;
          end
        end
        bri_pkg::BRI_IDLE, bri_pkg::BRI_IGNORE: begin
          bit_cnt <= 3'h0;
        end
        default: begin
          st <= bri_pkg::BRI_IDLE;
        end
      endcase
    end
  end

  // Data line drive: acknowledge bits and result bits, set on SCL falling edges and held while SCL is high.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe_o <= 1'b0;
    end else if (scl_fall) begin
      case (st)
        bri_pkg::BRI_ADDR_ACK, bri_pkg::BRI_WR_ACK: begin
          sda_oe_o <= ack_on ? (rw && st == bri_pkg::BRI_ADDR_ACK && !pkt[39])
                      : 1'b1;
        end
        bri_pkg::BRI_RD_BYTE: begin
          sda_oe_o <= ~pkt[39];
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Pointer and command decode of write transfers.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      got_ptr <= 1'b0;
      pointer <= 8'h00;
      trig    <= 1'b0;
    end else begin
      trig <= 1'b0;
      if (start_cond) begin
        got_ptr <= 1'b0;
      end else if (st == bri_pkg::BRI_WR_BYTE && last_bit) begin
        got_ptr <= 1'b1;
        if (!got_ptr) begin
          pointer <= byte_now;
        end else begin
          trig <= (pointer == `BRI_PTR_COMMAND) &&
                  (byte_now == `BRI_CMD_MEASURE);
        end
      end
    end
  end

  // Result packet: loaded at a matching read address, then only shifted.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pkt <= 40'hFFFFFFFFFF;
    end else if (st == bri_pkg::BRI_ADDR && last_bit &&
                 byte_now == {`BRI_SLAVE_ADDR, 1'b1}) begin
      pkt <= {press, temp};
    end else if (st == bri_pkg::BRI_RD_BYTE && scl_rise) begin
      pkt <= {pkt[38:0], 1'b1};
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o <= 1'b0;
    end else if (trig) begin
      busy_o <= 1'b1;
    end else if (done) begin
      busy_o <= 1'b0;
    end
  end

  bri_convert #(
    .PHASE_CYCLES (CONV_CYCLES / 2)
  ) u_convert (
    .mclk_i       (mclk_i),
    .arst_n_i     (arst_n_i),
    .start_i      (trig),
    .raw_press_i  (raw_press_i),
    .raw_temp_i   (raw_temp_i),
    .sensor_pwr_o (sensor_pwr_o),
    .adc_sel_o    (adc_sel_o),
    .done_o       (done),
    .press_o      (press),
    .temp_o       (temp)
  );

  property p_wrong_addr;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_ADDR && last_bit && !start_cond && !stop_cond &&
     byte_now[7:1] != `BRI_SLAVE_ADDR) |=> st == bri_pkg::BRI_IGNORE;
  endproperty
  a_wrong_addr: assert property (p_wrong_addr)
    else $error("Foreign address not ignored.");

  property p_trigger;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_WR_BYTE && last_bit && got_ptr && !start_cond &&
     pointer == `BRI_PTR_COMMAND && byte_now == `BRI_CMD_MEASURE)
      |=> trig ##1 busy_o;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("Measure command did not start a conversion.");

  property p_other_cmd;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_WR_BYTE && last_bit && got_ptr &&
     byte_now != `BRI_CMD_MEASURE) |=> !trig;
  endproperty
  a_other_cmd: assert property (p_other_cmd)
    else $error("Other command byte started a conversion.");

  property p_read_no_conv;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_RD_BYTE || st == bri_pkg::BRI_RD_ACK) |-> !trig;
  endproperty
  a_read_no_conv: assert property (p_read_no_conv)
    else $error("Read started a conversion.");

  property p_capture;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_ADDR && last_bit && !start_cond && !stop_cond &&
     byte_now == {`BRI_SLAVE_ADDR, 1'b1}) |=> pkt == $past({press, temp});
  endproperty
  a_capture: assert property (p_capture)
    else $error("Packet not captured at read address.");

  property p_pkt_stable;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st == bri_pkg::BRI_RD_BYTE && !scl_rise && !start_cond) |=> $stable(pkt);
  endproperty
  a_pkt_stable: assert property (p_pkt_stable)
    else $error("Packet changed during a read.");

  sequence s_ack_fall;
    st == bri_pkg::BRI_ADDR_ACK && scl_fall && !ack_on && !start_cond &&
    !stop_cond;
  endsequence
  property p_ack;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_ack_fall |=> sda_oe_o && !sda_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Address not acknowledged.");

  sequence s_nack;
    st == bri_pkg::BRI_RD_ACK && scl_rise && sda_i && !start_cond;
  endsequence
  property p_nack;
    @(posedge mclk_i) disable iff (!arst_n_i)
    s_nack |=> (st == bri_pkg::BRI_IGNORE && !sda_oe_o)[*2];
  endproperty
  a_nack: assert property (p_nack)
    else $error("Data still driven after not-acknowledge.");

  property p_sleep_boot;
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(sensor_pwr_o) |-> $past(trig);
  endproperty
  a_sleep_boot: assert property (p_sleep_boot)
    else $error("Sensor woke without a trigger.");
endmodule
`default_nettype wire

// [logic/bri_regs.svh]
// Constants of the barometer readout: address, pointers, commands, timing.
`ifndef BRI_REGS_SVH
`define BRI_REGS_SVH
`define BRI_SLAVE_ADDR     7'h6D
`define BRI_PTR_RESULT     8'h06
`define BRI_PTR_COMMAND    8'h30
`define BRI_CMD_MEASURE    8'h0A
`define BRI_CLK_MHZ        25
`define BRI_CONV_TIME_US   5000
`define BRI_CONV_CYCLES    (`BRI_CONV_TIME_US * `BRI_CLK_MHZ)
`define BRI_PRESS_FRAC     5
`define BRI_TEMP_FRAC      8
`define BRI_PRESS_TRIM     24'h000000
`define BRI_TEMP_TRIM      16'h0000
`define BRI_PRESS_RESET    24'h000000
`define BRI_TEMP_RESET     16'h0000
`endif

// [test/bri_host_model.sv]
// Behavioural I2C host controller that talks to the barometer readout.
`timescale 1ns/100ps
`default_nettype none
module bri_host_model (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic start();
    hw(1);
    sda_oe_o <= 1'b0;
    hw(4);
    scl_o <= 1'b1;
    hw(4);
    sda_oe_o <= 1'b1;
    hw(4);
    scl_o <= 1'b0;
    hw(4);
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    hw(4);
    scl_o <= 1'b1;
    hw(4);
    sda_oe_o <= 1'b0;
    hw(4);
  endtask
  task automatic bit_out(input logic b);
    sda_oe_o <= !b;
    hw(4);
    scl_o <= 1'b1;
    hw(4);
    scl_o <= 1'b0;
    hw(4);
  endtask
  task automatic bit_in(output logic b);
    sda_oe_o <= 1'b0;
    hw(4);
    scl_o <= 1'b1;
    hw(2);
    b = sda_i;
    hw(2);
    scl_o <= 1'b0;
    hw(4);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic nb;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(nb);
    ack = !nb;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 0; i < 8; i++) begin
      bit_in(b);
      d = {d[6:0], b};
    end
    bit_out(last);
  endtask
  task automatic trigger(input logic [6:0] a, input logic [7:0] ptr,
                         input logic [7:0] cmd, output logic [2:0] acks);
    start();
    wr_byte({a, 1'b0}, acks[2]);
    wr_byte(ptr, acks[1]);
    wr_byte(cmd, acks[0]);
    stop();
  endtask
  task automatic read(input int n, input int last,
                      output logic [47:0] d, output logic ok);
    logic       a1;
    logic       a2;
    logic       a3;
    logic [7:0] b;
    d = '0;
    start();
    wr_byte(8'hDA, a1);
    wr_byte(8'h06, a2);
    start();
    wr_byte(8'hDB, a3);
    for (int i = 0; i < n; i++) begin
      rd_byte(i >= last - 1, b);
      d = {d[39:0], b};
    end
    stop();
    ok = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking testbench of the barometer readout.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int CONV = 800;
  logic        mclk, arst_n, scl, h_oe, oe, sda_d, pwr, sel, busy;
  logic [23:0] raw_p;
  logic [15:0] raw_t;
  logic [47:0] d;
  logic [2:0]  acks;
  logic        ok;
  wire         sda_w = !(oe || h_oe);
  int          errors, tests_run, sel0, sel1, bad_pwr;
  bri_readout #(.CONV_CYCLES(CONV)) dut (
    .mclk_i(mclk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_d), .sda_oe_o(oe), .raw_press_i(raw_p),
    .raw_temp_i(raw_t), .sensor_pwr_o(pwr), .adc_sel_o(sel),
    .busy_o(busy));
  bri_host_model host (
    .mclk_i(mclk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(h_oe));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (pwr === 1'b1 && sel === 1'b0) sel0++;
    if (pwr === 1'b1 && sel === 1'b1) sel1++;
    if (arst_n && pwr !== 1'b0 && busy !== 1'b1) bad_pwr++;
  end
  task automatic chk(input string what, input logic [47:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_cnt(input string what, input int exp, got);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge mclk);
    while (busy !== 1'b0 && n < CONV * 2) begin
      @(negedge mclk);
      n++;
    end
    chk("busy_clear", 0, busy);
  endtask
  task automatic t_sleep();
    repeat (50) @(negedge mclk);
    chk("busy_sleep", 0, busy);
    chk("sda_level", 0, sda_d);
    chk_cnt("pwr_sleep", 0, sel0 + sel1);
    host.read(6, 5, d, ok);
    chk("read_ack", 1, ok);
    chk("reset_data", 48'hFF, d);
    $display("t_sleep done");
  endtask
  task automatic t_trigger(input logic [23:0] p, input logic [15:0] t);
    raw_p <= p;
    raw_t <= t;
    sel0 = 0;
    sel1 = 0;
    host.trigger(7'h6D, 8'h30, 8'h0A, acks);
    chk("trig_acks", 3'b111, acks);
    @(negedge mclk);
    chk("busy_run", 1, busy);
    wait_idle();
    chk_cnt("press_phase", CONV / 2, sel0);
    chk_cnt("temp_phase", CONV / 2, sel1);
    host.read(6, 5, d, ok);
    chk("read_ack", 1, ok);
    chk("packet", {p, t, 8'hFF}, d);
    $display("t_trigger done");
  endtask
  task automatic t_reread(input logic [23:0] p, input logic [15:0] t);
    sel0 = 0;
    host.read(3, 3, d, ok);
    chk("press_only", p, d[23:0]);
    host.read(5, 5, d, ok);
    chk("reread", {p, t}, d[39:0]);
    chk_cnt("no_conv", 0, sel0);
    $display("t_reread done");
  endtask
  task automatic t_addr();
    logic [6:0] al[3] = '{7'h6C, 7'h6F, 7'h2D};
    foreach (al[i]) begin
      host.trigger(al[i], 8'h30, 8'h0A, acks);
      chk("foreign_ack", 0, acks[2]);
    end
    @(negedge mclk);
    chk("foreign_busy", 0, busy);
    $display("t_addr done");
  endtask
  task automatic t_badcmd();
    logic [7:0] cl[3] = '{8'h0B, 8'h00, 8'hA0};
    foreach (cl[i]) begin
      host.trigger(7'h6D, 8'h30, cl[i], acks);
      chk("cmd_acks", 3'b111, acks);
      @(negedge mclk);
      chk("cmd_busy", 0, busy);
    end
    host.trigger(7'h6D, 8'h06, 8'h0A, acks);
    chk("ptr_acks", 3'b111, acks);
    @(negedge mclk);
    chk("ptr_busy", 0, busy);
    $display("t_badcmd done");
  endtask
  task automatic t_during(input logic [23:0] p, input logic [15:0] t);
    @(posedge mclk);
    raw_p <= 24'h1E8480;
    raw_t <= 16'h1900;
    host.trigger(7'h6D, 8'h30, 8'h0A, acks);
    @(negedge mclk);
    chk("busy_start", 1, busy);
    host.read(6, 5, d, ok);
    chk("old_packet", {p, t, 8'hFF}, d);
    wait_idle();
    host.read(5, 5, d, ok);
    chk("new_packet", {24'h1E8480, 16'h1900}, d[39:0]);
    $display("t_during done");
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end
  initial begin
    arst_n = 1'b0;
    raw_p = 24'h000000;
    raw_t = 16'h0000;
    errors = 0;
    tests_run = 0;
    sel0 = 0;
    sel1 = 0;
    bad_pwr = 0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_sleep();
    t_trigger(24'h32DCD5, 16'hF380);
    t_reread(24'h32DCD5, 16'hF380);
    t_addr();
    t_badcmd();
    t_during(24'h32DCD5, 16'hF380);
    chk_cnt("pwr_without_busy", 0, bad_pwr);
    test_done();
  end
endmodule
`default_nettype wire
